// ===== src/channel_cal_phase.sv
// Purpose: Per-channel offset/gain correction, sync phase delay, PGA, GPIO and power control
// Assumes: clk is the master clock; all inputs synchronous to clk; sync_pulse is one cycle
// Notes:   Register port is the decoded side of the serial host link, one byte per access
`timescale 1ns/10ps
`default_nettype none

module channel_cal_phase
  import cal_pkg::*;
#(
  parameter int               NUM_CH       = 8,
  parameter logic [23:0]      GAIN_FACTORY = 24'h555555
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire cal_pkg::reg_req_type     reg_req,
  output logic [7:0]                    reg_rd_data,
  output logic                          reg_rd_valid,
  input  wire logic                     format_select_low,
  input  wire logic                     format_select_high,
  input  wire logic                     sync_pulse,
  input  wire logic [11:0]              decimation_rate,
  output logic [11:0]                   applied_decimation,
  input  wire logic                     sample_in_valid,
  input  wire cal_pkg::sample_type      sample_in,
  output logic                          sample_out_valid,
  output cal_pkg::sample_type           sample_out,
  output logic [NUM_CH-1:0]             filter_start,
  output logic [2*NUM_CH-1:0]           pga_gain_code,
  input  wire logic [2:0]               gpio_in,
  output logic [2:0]                    gpio_out,
  output logic [2:0]                    gpio_oe,
  output cal_pkg::refbuf_mode_type      refbuf_pos_mode,
  output cal_pkg::refbuf_mode_type      refbuf_neg_mode,
  output logic                          common_mode_buffer_on,
  output logic                          int_ref_buf_on,
  output logic                          sar_on,
  output logic                          osc_on,
  output logic                          high_res_mode,
  output logic [7:0]                    sigma_delta_power_off,
  output logic                          serial_host_mode
);
  import cal_pkg::*;

  if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
    $error("NUM_CH must be 1 to 8");
  end

  typedef enum {ph_idle, ph_wait} phase_state_type;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register file state

  logic [7:0]  setup_q [NUM_CH];
  logic [7:0]  setup_d [NUM_CH];
  logic [7:0]  gain_u_q [NUM_CH];
  logic [7:0]  gain_u_d [NUM_CH];
  logic [7:0]  gain_m_q [NUM_CH];
  logic [7:0]  gain_m_d [NUM_CH];
  logic [23:0] gain_act_q [NUM_CH];
  logic [23:0] gain_act_d [NUM_CH];
  logic [7:0]  off_u_q [NUM_CH];
  logic [7:0]  off_u_d [NUM_CH];
  logic [7:0]  off_m_q [NUM_CH];
  logic [7:0]  off_m_d [NUM_CH];
  logic [23:0] off_act_q [NUM_CH];
  logic [23:0] off_act_d [NUM_CH];
  logic [7:0]  phase_raw_q [NUM_CH];
  logic [7:0]  phase_raw_d [NUM_CH];
  logic [7:0]  phase_rd_q [NUM_CH];
  logic [7:0]  phase_rd_d [NUM_CH];
  logic [2:0]  pin_dir_q, pin_dir_d;
  logic [2:0]  pin_data_q, pin_data_d;
  logic [7:0]  refbuf_en_q, refbuf_en_d;
  logic [7:0]  refbuf_pr_q, refbuf_pr_d;
  logic [7:0]  global_pwr_q, global_pwr_d;
  logic [7:0]  sd_off_q, sd_off_d;
  logic [2:0]  trig_ctrl_q, trig_ctrl_d;
  logic [7:0]  rd_data_q, rd_data_d;
  logic        rd_valid_q;
  logic        host_q, host_d;
  logic        strap_pend_q;
  logic [11:0] dec_q, dec_d;
  logic [2:0]  gpio_prev_q;
  logic [2:0]  gpio_out_q, gpio_oe_q;
  refbuf_mode_type pos_mode_q, neg_mode_q, pos_mode_d, neg_mode_d;

  logic        ch_space;
  logic [2:0]  ch_sel;
  logic [2:0]  fld_sel;
  logic        ch_ok;
  logic [12:0] ph_prod;
  logic [7:0]  ph_store;
  logic        trig_edge;

  // Scaling factor n as a shift, chosen by decimation range
  function automatic logic [2:0] dec_shift(input logic [11:0] dec);
    logic [12:0] d;
    d = {1'b0, dec};
    if (d <= LIM_X1) dec_shift = 3'h0;
    else if (d <= LIM_X2) dec_shift = 3'h1;
    else if (d <= LIM_X4) dec_shift = 3'h2;
    else if (d <= LIM_X8) dec_shift = 3'h3;
    else dec_shift = 3'h4;
  endfunction : dec_shift

  function automatic refbuf_mode_type buf_mode(input logic en, input logic pre);
    if (!en) buf_mode = refbuf_off;
    else if (pre) buf_mode = refbuf_precharge;
    else buf_mode = refbuf_on;
  endfunction : buf_mode

  assign ch_space = ~reg_req.addr[6];
  assign ch_sel   = reg_req.addr[5:3];
  assign fld_sel  = reg_req.addr[2:0];
  assign ch_ok    = ch_space && ({29'd0, ch_sel} < NUM_CH);
  assign ph_prod  = 13'({5'd0, reg_req.wdata} << dec_shift(dec_q));
  // Divide the product back down so it fits 8 bits; the readback never falls below the written value
  assign ph_store = (ph_prod <= LIM_X1) ? ph_prod[7:0] :
                    (ph_prod <= LIM_X2) ? ph_prod[8:1] :
                    (ph_prod <= LIM_X4) ? ph_prod[9:2] :
                    (ph_prod <= LIM_X8) ? ph_prod[10:3] : ph_prod[11:4];
  // Select code 3 names no pin; refuse it instead of indexing past the pins
  assign trig_edge = trig_ctrl_q[TRIG_EN_BIT] && host_q && (trig_ctrl_q[2:1] != 2'h3)
                   && !pin_dir_q[trig_ctrl_q[2:1]]
                   && gpio_in[trig_ctrl_q[2:1]] && !gpio_prev_q[trig_ctrl_q[2:1]];

  always_comb begin
    setup_d     = setup_q;
    gain_u_d    = gain_u_q;
    gain_m_d    = gain_m_q;
    gain_act_d  = gain_act_q;
    off_u_d     = off_u_q;
    off_m_d     = off_m_q;
    off_act_d   = off_act_q;
    phase_raw_d = phase_raw_q;
    phase_rd_d  = phase_rd_q;
    pin_dir_d   = pin_dir_q;
    pin_data_d  = pin_data_q;
    refbuf_en_d = refbuf_en_q;
    refbuf_pr_d = refbuf_pr_q;
    global_pwr_d = global_pwr_q;
    sd_off_d    = sd_off_q;
    trig_ctrl_d = trig_ctrl_q;
    rd_data_d   = rd_data_q;
    host_d      = host_q;
    dec_d       = dec_q;
    if (reg_req.wr_en && ch_ok) begin
      case (fld_sel)
        SETUP_IDX:  setup_d[ch_sel] = reg_req.wdata;
        GAIN_U_IDX: gain_u_d[ch_sel] = reg_req.wdata;
        GAIN_M_IDX: gain_m_d[ch_sel] = reg_req.wdata;
        // Lower byte commits the whole word so samples never see a half-written gain
        GAIN_L_IDX: gain_act_d[ch_sel] = {gain_u_q[ch_sel], gain_m_q[ch_sel], reg_req.wdata};
        OFF_U_IDX:  off_u_d[ch_sel] = reg_req.wdata;
        OFF_M_IDX:  off_m_d[ch_sel] = reg_req.wdata;
        OFF_L_IDX:  off_act_d[ch_sel] = {off_u_q[ch_sel], off_m_q[ch_sel], reg_req.wdata};
        PHASE_IDX: begin
          phase_raw_d[ch_sel] = reg_req.wdata;
          phase_rd_d[ch_sel]  = ph_store;
        end
        default: ;
      endcase
    end else if (reg_req.wr_en) begin
      case (reg_req.addr)
        PIN_DIR_ADDR:    pin_dir_d = reg_req.wdata[2:0];
        PIN_LEVEL_ADDR:  pin_data_d = reg_req.wdata[2:0];
        REFBUF_EN_ADDR:  refbuf_en_d = reg_req.wdata;
        REFBUF_PR_ADDR:  refbuf_pr_d = reg_req.wdata;
        GLOBAL_PWR_ADDR: global_pwr_d = reg_req.wdata;
        SD_OFF_ADDR:     sd_off_d = reg_req.wdata;
        TRIG_CTRL_ADDR:  trig_ctrl_d = reg_req.wdata[2:0];
        default: ;
      endcase
    end
    if (reg_req.rd_en) begin
      rd_data_d = 8'h00;
      if (ch_ok) begin
        case (fld_sel)
          SETUP_IDX:  rd_data_d = setup_q[ch_sel];
          GAIN_U_IDX: rd_data_d = gain_u_q[ch_sel];
          GAIN_M_IDX: rd_data_d = gain_m_q[ch_sel];
          GAIN_L_IDX: rd_data_d = gain_act_q[ch_sel][7:0];
          OFF_U_IDX:  rd_data_d = off_u_q[ch_sel];
          OFF_M_IDX:  rd_data_d = off_m_q[ch_sel];
          OFF_L_IDX:  rd_data_d = off_act_q[ch_sel][7:0];
          PHASE_IDX:  rd_data_d = phase_rd_q[ch_sel];
          default:    rd_data_d = 8'h00;
        endcase
      end else begin
        case (reg_req.addr)
          PIN_DIR_ADDR:    rd_data_d = {5'h00, pin_dir_q};
          // Outputs read back what is driven, inputs what is on the pin
          PIN_LEVEL_ADDR:  rd_data_d = {5'h00, (pin_dir_q & pin_data_q) | (~pin_dir_q & gpio_in)};
          REFBUF_EN_ADDR:  rd_data_d = refbuf_en_q;
          REFBUF_PR_ADDR:  rd_data_d = refbuf_pr_q;
          GLOBAL_PWR_ADDR: rd_data_d = global_pwr_q;
          SD_OFF_ADDR:     rd_data_d = sd_off_q;
          TRIG_CTRL_ADDR:  rd_data_d = {5'h00, trig_ctrl_q};
          default:         rd_data_d = 8'h00;
        endcase
      end
    end
    if (sync_pulse || strap_pend_q) begin
      host_d = format_select_low && format_select_high;
    end
    if (sync_pulse || trig_edge) begin
      dec_d = decimation_rate;
    end
    pos_mode_d = buf_mode(refbuf_en_q[POS_EN_BIT], refbuf_pr_q[POS_PRE_BIT]);
    neg_mode_d = buf_mode(refbuf_en_q[NEG_EN_BIT], refbuf_pr_q[NEG_PRE_BIT]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        setup_q[i]     <= SETUP_RST;
        gain_u_q[i]    <= GAIN_FACTORY[23:16];
        gain_m_q[i]    <= GAIN_FACTORY[15:8];
        gain_act_q[i]  <= GAIN_FACTORY;
        off_u_q[i]     <= 8'h00;
        off_m_q[i]     <= 8'h00;
        off_act_q[i]   <= 24'h000000;
        phase_raw_q[i] <= 8'h00;
        phase_rd_q[i]  <= 8'h00;
      end
      pin_dir_q    <= 3'h0;
      pin_data_q   <= 3'h0;
      refbuf_en_q  <= REFBUF_EN_RST;
      refbuf_pr_q  <= REFBUF_PR_RST;
      global_pwr_q <= GLOBAL_PWR_RST;
      sd_off_q     <= SD_OFF_RST;
      trig_ctrl_q  <= 3'h0;
      rd_data_q    <= 8'h00;
      rd_valid_q   <= 1'b0;
      host_q       <= 1'b0;
      strap_pend_q <= 1'b1;
      dec_q        <= 12'h000;
      gpio_prev_q  <= 3'h0;
      gpio_out_q   <= 3'h0;
      gpio_oe_q    <= 3'h0;
      pos_mode_q   <= refbuf_precharge;
      neg_mode_q   <= refbuf_precharge;
    end else begin
      setup_q      <= setup_d;
      gain_u_q     <= gain_u_d;
      gain_m_q     <= gain_m_d;
      gain_act_q   <= gain_act_d;
      off_u_q      <= off_u_d;
      off_m_q      <= off_m_d;
      off_act_q    <= off_act_d;
      phase_raw_q  <= phase_raw_d;
      phase_rd_q   <= phase_rd_d;
      pin_dir_q    <= pin_dir_d;
      pin_data_q   <= pin_data_d;
      refbuf_en_q  <= refbuf_en_d;
      refbuf_pr_q  <= refbuf_pr_d;
      global_pwr_q <= global_pwr_d;
      sd_off_q     <= sd_off_d;
      trig_ctrl_q  <= trig_ctrl_d;
      rd_data_q    <= rd_data_d;
      rd_valid_q   <= reg_req.rd_en;
      host_q       <= host_d;
      strap_pend_q <= 1'b0;
      dec_q        <= dec_d;
      gpio_prev_q  <= gpio_in;
      gpio_out_q   <= pin_data_q;
      gpio_oe_q    <= pin_dir_q & {3{host_q}};
      pos_mode_q   <= pos_mode_d;
      neg_mode_q   <= neg_mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Modulator clock enable

  logic [3:0] mod_cnt_q, mod_cnt_d;
  logic       mod_en;
  logic [3:0] mod_div;

  assign mod_div = global_pwr_q[HIRES_BIT] ? MOD_DIV_HR : MOD_DIV_LP;
  assign mod_en  = (mod_cnt_q == mod_div - 4'h1);

  always_comb begin
    // Restart on sync so all channels count delays from one common edge
    if (sync_pulse || mod_en) mod_cnt_d = 4'h0;
    else mod_cnt_d = mod_cnt_q + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (rst) mod_cnt_q <= 4'h0;
    else mod_cnt_q <= mod_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Per-channel sync phase delay

  logic [11:0] delay_cnt_q [NUM_CH];
  logic [NUM_CH-1:0] start_q;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_phase
      phase_state_type st_q, st_d;
      logic [11:0] cnt_d;
      logic        start_d;
      logic [15:0] scaled;

      assign scaled = 16'({8'h00, phase_raw_q[g]} << dec_shift(decimation_rate));

      always_comb begin
        st_d    = st_q;
        cnt_d   = delay_cnt_q[g];
        start_d = 1'b0;
        case (st_q)
          ph_idle: ;
          ph_wait: begin
            if (mod_en) begin
              if (delay_cnt_q[g] == 12'h000) begin
                start_d = 1'b1;
                st_d    = ph_idle;
              end else begin
                cnt_d = delay_cnt_q[g] - 12'h001;
              end
            end
          end
          default: st_d = ph_idle;
        endcase
        // Phase value is captured only here; later writes wait for the next sync
        if (sync_pulse) begin
          st_d = ph_wait;
          if (decimation_rate == 12'h000) cnt_d = 12'h000;
          else if (scaled >= {4'h0, decimation_rate}) cnt_d = decimation_rate - 12'h001;
          else cnt_d = scaled[11:0];
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          st_q           <= ph_idle;
          delay_cnt_q[g] <= 12'h000;
          start_q[g]     <= 1'b0;
        end else begin
          st_q           <= st_d;
          delay_cnt_q[g] <= cnt_d;
          start_q[g]     <= start_d;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Correction datapath: out = ((3*x - 4*off) * gain + 2^23) >>> 24, which is
  // (x - 4/3*off) * gain / 0x555555 with round to nearest

  logic signed [26:0] pre_sum;
  logic signed [51:0] prod;
  logic signed [51:0] rnd;
  logic signed [27:0] scaled_out;
  logic [23:0]        sat_d;
  logic               out_valid_q;
  sample_type         out_q;
  logic [23:0]        x_in;
  logic [23:0]        off_in;
  logic [23:0]        gain_in;

  assign x_in    = sample_in.data;
  assign off_in  = off_act_q[sample_in.chan];
  assign gain_in = gain_act_q[sample_in.chan];

  always_comb begin
    pre_sum = 27'($signed({{3{x_in[23]}}, x_in}) * 27'sd3)
            - 27'($signed({{3{off_in[23]}}, off_in}) <<< 2);
    prod = $signed({{25{pre_sum[26]}}, pre_sum}) * $signed({28'd0, gain_in});
    rnd = prod + ROUND_HALF;
    scaled_out = rnd[51:24];
    if (scaled_out > 28'sh07fffff) sat_d = 24'h7fffff;
    else if (scaled_out < -28'sh0800000) sat_d = 24'h800000;
    else sat_d = scaled_out[23:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_q <= 1'b0;
      out_q       <= '0;
    end else begin
      out_valid_q <= sample_in_valid;
      if (sample_in_valid) out_q <= '{chan: sample_in.chan, data: sat_d};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rd_data           = rd_data_q;
  assign reg_rd_valid          = rd_valid_q;
  assign applied_decimation    = dec_q;
  assign sample_out_valid      = out_valid_q;
  assign sample_out            = out_q;
  assign filter_start          = start_q;
  assign gpio_out              = gpio_out_q;
  assign gpio_oe               = gpio_oe_q;
  assign refbuf_pos_mode       = pos_mode_q;
  assign refbuf_neg_mode       = neg_mode_q;
  assign common_mode_buffer_on = global_pwr_q[CM_BIT];
  assign int_ref_buf_on        = global_pwr_q[IREF_BIT];
  assign sar_on                = global_pwr_q[SAR_BIT];
  assign osc_on                = global_pwr_q[OSC_BIT];
  assign high_res_mode         = global_pwr_q[HIRES_BIT];
  assign sigma_delta_power_off = sd_off_q;
  assign serial_host_mode      = host_q;
  for (g = 0; g < NUM_CH; g++) begin : g_pga
    assign pga_gain_code[2*g +: 2] = setup_q[g][PGA_LO +: 2];
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_sync_zero_ch0;
    sync_pulse && phase_raw_q[0] == 8'h00 && decimation_rate != 12'h000;
  endsequence

  sequence s_hr_quiet;
    (!sync_pulse && global_pwr_q[HIRES_BIT])[*3];
  endsequence

  a_gain_reset: assert property (@(posedge clk) $past(rst) && !rst |-> gain_act_q[0] == GAIN_FACTORY)
    else $error("gain word not at factory value after reset");
  a_offset_reset: assert property (@(posedge clk) $past(rst) && !rst |-> off_act_q[0] == 24'h000000)
    else $error("offset word not cleared after reset");
  a_unity_pass: assert property (@(posedge clk) disable iff (rst)
      sample_in_valid && gain_in == GAIN_UNITY && off_in == 24'h000000
      |=> sample_out.data == $past(sample_in.data))
    else $error("unity gain and zero offset changed the sample");
  a_offset_step: assert property (@(posedge clk) disable iff (rst)
      sample_in_valid && x_in == 24'h000000 && gain_in == GAIN_UNITY && off_in == 24'h000003
      |=> sample_out.data == 24'hfffffc)
    else $error("offset of three did not give minus four");
  a_sat_positive: assert property (@(posedge clk) disable iff (rst)
      sample_in_valid && x_in == 24'h7fffff && gain_in == 24'hffffff && off_in == 24'h000000
      |=> sample_out.data == 24'h7fffff)
    else $error("overflow wrapped instead of saturating");
  a_word_atomic: assert property (@(posedge clk) disable iff (rst)
      reg_req.wr_en && reg_req.addr == {4'h0, GAIN_U_IDX} |=> $stable(gain_act_q[0]))
    else $error("partial gain write reached the datapath");
  a_phase_hold: assert property (@(posedge clk) disable iff (rst)
      !sync_pulse && !mod_en |=> $stable(delay_cnt_q[0]))
    else $error("phase delay changed outside sync and modulator tick");
  a_phase_clip: assert property (@(posedge clk) disable iff (rst)
      sync_pulse && decimation_rate != 12'h000 |=> delay_cnt_q[0] < $past(decimation_rate))
    else $error("phase delay not clipped below decimation");
  a_start_delay: assert property (@(posedge clk) disable iff (rst)
      s_sync_zero_ch0 |-> ##[1:9] filter_start[0])
    else $error("zero phase delay did not start the filter in time");
  a_mod_rate: assert property (@(posedge clk) disable iff (rst)
      mod_en && !sync_pulse && global_pwr_q[HIRES_BIT] ##1 s_hr_quiet
      |=> mod_en || !global_pwr_q[HIRES_BIT])
    else $error("modulator tick not every four clocks");
  a_gpio_oe: assert property (@(posedge clk) disable iff (rst)
      !host_q |=> gpio_oe == 3'h0)
    else $error("gpio driven outside host mode");
  a_refbuf_off: assert property (@(posedge clk) disable iff (rst)
      !refbuf_en_q[POS_EN_BIT] |=> refbuf_pos_mode == refbuf_off)
    else $error("positive reference buffer not disabled");
endmodule : channel_cal_phase

`default_nettype wire

// ===== common/cal_pkg.sv
// Purpose: Shared constants and types for the channel calibration and phase control block
// Assumes: Byte-wide registers reached through a decoded serial-host register port
// Notes:   Channel n registers sit at n*8 plus a field index; globals sit from 0x40
package cal_pkg;
  localparam int WORD_W = 24;
  localparam int DEC_W  = 12;
  localparam int GPIO_W = 3;
  localparam int ADDR_W = 7;

  // Field index inside a channel block
  localparam logic [2:0] SETUP_IDX  = 3'h0;
  localparam logic [2:0] GAIN_U_IDX = 3'h1;
  localparam logic [2:0] GAIN_M_IDX = 3'h2;
  localparam logic [2:0] GAIN_L_IDX = 3'h3;
  localparam logic [2:0] OFF_U_IDX  = 3'h4;
  localparam logic [2:0] OFF_M_IDX  = 3'h5;
  localparam logic [2:0] OFF_L_IDX  = 3'h6;
  localparam logic [2:0] PHASE_IDX  = 3'h7;

  // Global registers
  localparam logic [6:0] PIN_DIR_ADDR   = 7'h40;
  localparam logic [6:0] PIN_LEVEL_ADDR = 7'h41;
  localparam logic [6:0] REFBUF_EN_ADDR = 7'h42;
  localparam logic [6:0] REFBUF_PR_ADDR = 7'h43;
  localparam logic [6:0] GLOBAL_PWR_ADDR = 7'h44;
  localparam logic [6:0] SD_OFF_ADDR    = 7'h45;
  localparam logic [6:0] TRIG_CTRL_ADDR = 7'h46;

  // Reset values
  localparam logic [7:0]  REFBUF_EN_RST  = 8'h18;
  localparam logic [7:0]  REFBUF_PR_RST  = 8'hc0;
  localparam logic [7:0]  GLOBAL_PWR_RST = 8'h64;
  localparam logic [7:0]  SD_OFF_RST     = 8'h00;
  localparam logic [7:0]  SETUP_RST      = 8'h00;
  localparam logic [23:0] GAIN_UNITY     = 24'h555555;

  // Field positions
  localparam int PGA_LO      = 6;
  localparam int POS_EN_BIT  = 4;
  localparam int NEG_EN_BIT  = 3;
  localparam int POS_PRE_BIT = 7;
  localparam int NEG_PRE_BIT = 6;
  localparam int HIRES_BIT   = 6;
  localparam int CM_BIT      = 5;
  localparam int IREF_BIT    = 4;
  localparam int SAR_BIT     = 3;
  localparam int OSC_BIT     = 2;
  localparam int TRIG_EN_BIT = 0;
  localparam int TRIG_SEL_LO = 1;

  // Modulator clock divide per power mode
  localparam logic [3:0] MOD_DIV_HR = 4'h4;
  localparam logic [3:0] MOD_DIV_LP = 4'h8;

  // Phase scaling range limits
  localparam logic [12:0] LIM_X1  = 13'h00ff;
  localparam logic [12:0] LIM_X2  = 13'h01ff;
  localparam logic [12:0] LIM_X4  = 13'h03ff;
  localparam logic [12:0] LIM_X8  = 13'h07ff;

  localparam logic signed [51:0] ROUND_HALF = 52'sh0000000800000;

  typedef enum logic [1:0] {refbuf_off, refbuf_on, refbuf_precharge} refbuf_mode_type;

  typedef struct packed {
    logic [2:0]  chan;
    logic [23:0] data;
  } sample_type;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_type;
endpackage : cal_pkg

// ===== dv/host_model.sv
// Purpose: Serial host model issuing byte accesses and sync
// Assumes: Requests launched on falling edges
// Notes:   Ties both format pins high
`timescale 1ns/10ps
`default_nettype none
module host_model
  import cal_pkg::*;
(
  input  wire logic            clk,
  input  wire logic [7:0]      rd_data,
  output cal_pkg::reg_req_type req,
  output logic                 sync,
  output logic                 fmt
);
  initial begin
    req = '0;
    sync = 1'b0;
    fmt = 1'b1;
  end
  task automatic acc(input logic [16:0] r, output logic [7:0] d);
    @(negedge clk);
    req = r;
    @(negedge clk);
    req = '0;
    d = rd_data;
  endtask : acc
  // Only the first buffer change in the bench is followed by a resync; the later 0x42 write is not
  task automatic pulse;
    @(negedge clk);
    sync = 1'b1;
    @(negedge clk);
    sync = 1'b0;
  endtask : pulse
endmodule : host_model
`default_nettype wire

// ===== dv/channel_cal_phase_tb_top.sv
// Purpose: Register-call bench for calibration and phase control
// Assumes: Host model drives the register port
// Notes:   Expectations come from the correction formula
`timescale 1ns/10ps
`default_nettype none
module channel_cal_phase_tb_top;
  import cal_pkg::*;
  logic clk, rst, sv, ov, hm, sy, fm, cm, ir, sr, os, hr, rv;
  logic [7:0] rdd, pw, d, fs;
  logic [11:0] ad, dr;
  logic [15:0] pg;
  logic [2:0] go, oe, gi;
  refbuf_mode_type pm, nm;
  sample_type si, so;
  reg_req_type rq;
  int errors, checks, k;
  host_model u_host_model (.clk(clk), .rd_data(rdd), .req(rq), .sync(sy), .fmt(fm));
  channel_cal_phase u_channel_cal_phase (.clk(clk), .rst(rst), .reg_req(rq),
    .reg_rd_data(rdd), .reg_rd_valid(rv), .format_select_low(fm), .format_select_high(fm),
    .sync_pulse(sy), .decimation_rate(dr), .applied_decimation(ad),
    .sample_in_valid(sv), .sample_in(si), .sample_out_valid(ov), .sample_out(so),
    .filter_start(fs), .pga_gain_code(pg), .gpio_in(gi), .gpio_out(go), .gpio_oe(oe),
    .refbuf_pos_mode(pm), .refbuf_neg_mode(nm), .common_mode_buffer_on(cm),
    .int_ref_buf_on(ir), .sar_on(sr), .osc_on(os), .high_res_mode(hr),
    .sigma_delta_power_off(pw), .serial_host_mode(hm));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    u_host_model.acc({2'b10, a, v}, d);
  endtask : wr
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    u_host_model.acc({2'b01, a, 8'h00}, d);
    chk({15'h0, rv, d}, {16'h1, e});
  endtask : rc
  task automatic smp(input logic [2:0] c, input logic [23:0] x, input logic [23:0] e);
    @(negedge clk);
    sv = 1'b1;
    si = '{c, x};
    @(negedge clk);
    sv = 1'b0;
    chk({ov, so.data[22:0]}, {1'b1, e[22:0]});
    chk(so.data, e);
  endtask : smp
  // Counts cycles from raising sync to the falling edge where channel 0 filter start is seen, one more than from the taken sync edge
  task automatic dly(input int e);
    u_host_model.pulse();
    k = 1;
    while (fs[0] !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    chk(k[23:0], e[23:0]);
  endtask : dly
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #320000;
    errors++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    sv = 1'b0;
    dr = 12'd300;
    gi = 3'b010;
    si = '0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rc(7'h42, 8'h18);
    rc(7'h43, 8'hc0);
    rc(7'h44, 8'h64);
    rc(7'h45, 8'h00);
    chk({15'h0, hr, pm, nm, cm, ir, sr, os}, 24'h1a9);
    rc(7'h03, 8'h55);
    rc(7'h06, 8'h00);
    rc(7'h50, 8'h00);
    $display("reset test done");
    smp(3'h0, 24'h3, 24'h3);
    wr(7'h04, 8'hff);
    wr(7'h05, 8'hff);
    wr(7'h06, 8'h6a);
    smp(3'h0, 24'h0, 24'd200);
    wr(7'h16, 8'h03);
    smp(3'h2, 24'h0, 24'hfffffc);
    wr(7'h09, 8'h40);
    wr(7'h0a, 8'h00);
    wr(7'h0b, 8'h00);
    wr(7'h0e, 8'h01);
    smp(3'h1, 24'h0, 24'hffffff);
    wr(7'h09, 8'hff);
    smp(3'h1, 24'h0, 24'hffffff);
    wr(7'h0a, 8'hff);
    wr(7'h0b, 8'hff);
    wr(7'h0e, 8'h00);
    smp(3'h1, 24'h7fffff, 24'h7fffff);
    smp(3'h1, 24'h800000, 24'h800000);
    wr(7'h01, 8'h2a);
    smp(3'h0, 24'h3, 24'd203);
    $display("datapath test done");
    u_host_model.pulse();
    wr(7'h07, 8'd3);
    rc(7'h07, 8'd6);
    dly(29);
    wr(7'h07, 8'd200);
    rc(7'h07, 8'd200);
    dly(1201);
    wr(7'h07, 8'h00);
    wr(7'h44, 8'h24);
    dly(9);
    $display("phase test done");
    for (int c = 0; c < 4; c++) begin
      wr(7'h10, {c[1:0], 6'h0});
      chk({22'h0, pg[5:4]}, c[23:0]);
    end
    wr(7'h40, 8'h05);
    wr(7'h41, 8'h03);
    wr(7'h42, 8'h10);
    wr(7'h43, 8'h40);
    wr(7'h45, 8'h81);
    u_host_model.pulse();
    chk({hm, oe, go, pm, nm, pw}, {1'b1, 3'h5, 3'h3, 2'd1, 2'd0, 8'h81});
    wr(7'h42, 8'h08);
    @(negedge clk);
    chk({20'h0, pm, nm}, 24'h2);
    gi = 3'b000;
    dr = 12'd600;
    rc(7'h41, 8'h01);
    wr(7'h46, 8'h03);
    chk({12'h0, ad}, 24'd300);
    gi = 3'b010;
    @(negedge clk);
    chk({12'h0, ad}, 24'd600);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rc(7'h0b, 8'h55);
    $display("control test done");
    final_report();
  end
endmodule : channel_cal_phase_tb_top
`default_nettype wire
